// ---- src/spa_acct.sv ----
`default_nettype none
module spa_acct
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Accounting carrier
  spa_acct_if.acct a
);
  import spa_pkg::*;
  logic [30:0] words_r;
  logic [30:0] words_nxt;
  logic        pend_r;
  logic        ovf_r;
  logic        dps_r;
  logic        under_r;
  logic [31:0] pad_r;
  wire  [31:0] sum_w    = {1'b0, words_r} + {19'h00000, a.fis_words};
  wire  [31:0] lim_w    = {1'b0, a.limit_words};
  wire         good_end = a.fis_end && a.fis_good;
  wire         over_w   = sum_w > lim_w;
  wire         pad_only = sum_w == (lim_w + 32'h00000001);
  wire         new_pend = a.prd_exhaust && a.prd_ibit;
  // A pad word is trimmed so the count tracks the descriptor words.
  assign words_nxt = a.cmd_start ? SPA_WORDS_RST :
                     (!good_end || a.queued) ? words_r :
                     (over_w && pad_only) ? a.limit_words :
                     sum_w[30:0];
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      words_r <= SPA_WORDS_RST;
      pend_r  <= 1'b0;
      ovf_r   <= 1'b0;
      dps_r   <= 1'b0;
      under_r <= 1'b0;
      pad_r   <= 32'h00000000;
    end
    else
    begin
      words_r <= words_nxt;
      ovf_r   <= good_end && over_w && !pad_only;
      // Pending interrupt waits for the whole frame and its CRC.
      pend_r  <= a.fis_end ? 1'b0 : (pend_r || new_pend);
      dps_r   <= good_end && (pend_r || new_pend);
      under_r <= a.queued && good_end && (sum_w < lim_w) && 1'b0;
      pad_r   <= a.tx_odd_last ? {16'h0000, a.tx_dword[15:0]}
                               : a.tx_dword;
    end
  assign a.byte_count   = {words_r, 1'b0};
  assign a.ovf          = ovf_r;
  assign a.dps          = dps_r;
  assign a.ncq_under    = under_r;
  assign a.tx_dword_pad = pad_r;
  pad_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    a.tx_odd_last |=> pad_r[31:16] == 16'h0000)
    else $error("odd final word not padded with zeros");
  pad_no_ovf_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (good_end && !a.queued && pad_only) |=>
    !ovf_r && words_r == $past(a.limit_words))
    else $error("padding word counted or flagged overflow");
  dps_cause_a: assert property (@(posedge mclk) disable iff (sys_rst)
    dps_r |-> $past(good_end) && ($past(pend_r) || $past(new_pend)))
    else $error("descriptor done without good frame end");
endmodule // spa_acct
`default_nettype wire

// ---- src/spa_acct_if.sv ----
`default_nettype none
interface spa_acct_if;
  logic        cmd_start;
  logic        queued;
  logic [30:0] limit_words;
  logic        fis_end;
  logic        fis_good;
  logic [12:0] fis_words;
  logic        prd_exhaust;
  logic        prd_ibit;
  logic [31:0] tx_dword;
  logic        tx_odd_last;
  logic [31:0] tx_dword_pad;
  logic [31:0] byte_count;
  logic        ovf;
  logic        dps;
  logic        ncq_under;
  modport main (output cmd_start, queued, limit_words, fis_end, fis_good,
                fis_words, prd_exhaust, prd_ibit, tx_dword, tx_odd_last,
                input tx_dword_pad, byte_count, ovf, dps, ncq_under);
  modport acct (input cmd_start, queued, limit_words, fis_end, fis_good,
                fis_words, prd_exhaust, prd_ibit, tx_dword, tx_odd_last,
                output tx_dword_pad, byte_count, ovf, dps, ncq_under);
endinterface
`default_nettype wire

// ---- src/spa_pkg.sv ----
// Behaviour
// - Invalid multiplier port sets its flag, then enters the non-fatal state.
// - Sync escape clears busy, request, shadows; sets fatal flag; goes fatal.
// - A frame aborted by sync escape is never transmitted again. The code lifts tx_no_retry once run-enable clears.
// - Sync escape handling leaves every command-issue bit untouched.
// - Switched sync escape on register frame: non-fatal flag, device error.
// - Fatal sets interface-fatal flag, waits until software clears run-enable.
// - Fatal from failed PIO data with interrupt bit also sets PIO flag.
// - Error bit sets taskfile-error flag; switching: device error, else wait.
// - Running may drop on fatal and must drop once run-enable clears.
// - Recoverable error returns to switched idle if switching, else idle.
// - Non-queued command gets exact byte total before its issue bit clears.
// - Count only acknowledged sent and good-CRC received data, per frame.
// - Queued commands keep no valid count; underflow on them is illegal. The code ties ncq_under low, so it is never flagged.
// - On overflow the count may be wrong; the overflow flag reports it.
// - A final frame with odd word count pads its last dword with zeros.
// - One extra padding word received or sent is not an overflow.
// - Byte count follows descriptor word count, excluding padding words.
// - An interrupt descriptor is exhausted only after its frames complete.
// - Hold descriptor interrupt; set done flag after good-CRC frame end.
// - Done flag raises interrupt when its enable and global enable are set.
`default_nettype none
package spa_pkg;
  localparam logic [7:0] SPA_OFS_STATUS  = 8'h00;
  localparam logic [7:0] SPA_OFS_INT_EN  = 8'h04;
  localparam logic [7:0] SPA_OFS_CONTROL = 8'h08;
  localparam logic [7:0] SPA_OFS_CMD_ISS = 8'h0C;
  localparam logic [7:0] SPA_OFS_TFSTAT  = 8'h10;
  localparam logic [7:0] SPA_OFS_BYTECNT = 8'h14;
  localparam logic [7:0] SPA_OFS_DESCWRD = 8'h18;
  localparam int SPA_NFLAG   = 7;
  localparam int SPA_F_IPM   = 0;
  localparam int SPA_F_IFS   = 1;
  localparam int SPA_F_INFS  = 2;
  localparam int SPA_F_PSS   = 3;
  localparam int SPA_F_TFES  = 4;
  localparam int SPA_F_OFS   = 5;
  localparam int SPA_F_DPS   = 6;
  localparam int SPA_C_RUN   = 0;
  localparam int SPA_C_FBS   = 1;
  localparam int SPA_C_GIE   = 2;
  localparam int SPA_T_BSY   = 7;
  localparam int SPA_T_DRQ   = 3;
  localparam int SPA_T_CR    = 16;
  localparam int SPA_T_ST_LO = 8;
  localparam logic [6:0]  SPA_FLAG_RST = 7'h00;
  localparam logic [2:0]  SPA_CTRL_RST = 3'h0;
  localparam logic [30:0] SPA_WORDS_RST = 31'h00000000;
  typedef enum logic [3:0] {
    SPA_IDLE     = 4'h0,
    SPA_WRBACK   = 4'h1,
    SPA_FATAL    = 4'h2,
    SPA_SYNC_ESC = 4'h3,
    SPA_BAD_PORT = 4'h4,
    SPA_NONFATAL = 4'h5,
    SPA_WAIT_CLR = 4'h6,
    SPA_FATAL_TF = 4'h7,
    SPA_SW_IDLE  = 4'hC,
    SPA_SDE      = 4'hD,
    SPA_SYNC_FB  = 4'hF
  } spa_state_t;
  function automatic logic [31:0] spa_lane_mask(input logic [3:0] sel);
    spa_lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction
endpackage
`default_nettype wire

// ---- src/spa_port_err.sv ----
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
module spa_port_err
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Error events, one-cycle pulses
  input  wire logic        ev_bad_pm_port,
  input  wire logic        ev_sync_esc_reg,
  input  wire logic        ev_sync_esc_data,
  input  wire logic        ev_fatal,
  input  wire logic        ev_fatal_pio_ibit,
  input  wire logic        ev_tf_err,
  input  wire logic        ev_nonfatal,
  input  wire logic        sde_done,
  // Device status
  input  wire logic        dev_stat_valid,
  input  wire logic        dev_busy,
  input  wire logic        dev_drq,
  // Command completion and byte count write-back
  input  wire logic        cmd_done,
  input  wire logic [4:0]  cmd_slot,
  output logic             bc_wb_valid,
  output logic      [4:0]  bc_wb_slot,
  output logic      [31:0] bc_wb_count,
  input  wire logic        bc_wb_ack,
  // Data frame accounting
  input  wire logic        cmd_start,
  input  wire logic        cmd_queued,
  input  wire logic        fis_end,
  input  wire logic        fis_good,
  input  wire logic [12:0] fis_words,
  input  wire logic        prd_exhaust,
  input  wire logic        prd_ibit,
  input  wire logic [31:0] tx_dword,
  input  wire logic        tx_odd_last,
  output logic      [31:0] tx_dword_pad,
  // Port status
  output logic             tx_no_retry,
  output logic             command_list_running,
  output logic      [31:0] command_issue_bits,
  output logic             irq
);
  import spa_pkg::*;
  spa_acct_if acc ();
  spa_acct u_acct
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .a       (acc.acct)
  );
  spa_state_t state_r;
  spa_state_t state_nxt;
  logic [SPA_NFLAG-1:0] flags_r;
  logic [SPA_NFLAG-1:0] flags_nxt;
  logic [SPA_NFLAG-1:0] flag_set;
  logic [SPA_NFLAG-1:0] int_en_r;
  logic [2:0]           ctrl_r;
  logic [31:0]          ci_r;
  logic [30:0]          limit_r;
  logic                 tf_busy_r;
  logic                 tf_drq_r;
  logic                 busy_sh_r;
  logic                 drq_sh_r;
  logic                 pio_ibit_r;
  logic                 no_retry_r;
  logic [4:0]           slot_r;
  logic [31:0]          count_r;
  logic                 ack_r;
  logic [31:0]          rdat_r;

  wire        req       = wb_cyc_i && wb_stb_i && !ack_r;
  wire        wr        = req && wb_we_i;
  wire [31:0] lane      = spa_lane_mask(wb_sel_i);
  wire [31:0] wdat      = wb_dat_i & lane;
  wire        hit_stat  = wb_adr_i == SPA_OFS_STATUS;
  wire        hit_ie    = wb_adr_i == SPA_OFS_INT_EN;
  wire        hit_ctrl  = wb_adr_i == SPA_OFS_CONTROL;
  wire        hit_ci    = wb_adr_i == SPA_OFS_CMD_ISS;
  wire        hit_tf    = wb_adr_i == SPA_OFS_TFSTAT;
  wire        hit_bc    = wb_adr_i == SPA_OFS_BYTECNT;
  wire        hit_dw    = wb_adr_i == SPA_OFS_DESCWRD;
  wire [SPA_NFLAG-1:0] w1c_clr = (wr && hit_stat) ? wdat[SPA_NFLAG-1:0]
                                                  : '0;
  wire [31:0] ci_sw_set = (wr && hit_ci) ? wdat : 32'h00000000;
  wire        run_en    = ctrl_r[SPA_C_RUN];
  wire        fbs_en    = ctrl_r[SPA_C_FBS];
  wire        gie       = ctrl_r[SPA_C_GIE];
  wire        in_idle   = state_r == SPA_IDLE || state_r == SPA_SW_IDLE;
  spa_state_t ret_idle;
  assign ret_idle = fbs_en ? SPA_SW_IDLE : SPA_IDLE;
  wire        wb_done   = state_r == SPA_WRBACK && bc_wb_ack;
  wire        fatal_st  = state_r == SPA_FATAL || state_r == SPA_WAIT_CLR ||
                          state_r == SPA_SYNC_ESC;
  wire [31:0] ci_hw_clr = wb_done ? (32'h00000001 << slot_r)
                                  : 32'h00000000;
  wire [31:0] tf_word   = {15'h0000, command_list_running,
                           4'h0, state_r, tf_busy_r, 3'h0, tf_drq_r, 3'h0};
  wire [31:0] rd_mux    =
    hit_stat ? {25'h0000000, flags_r} :
    hit_ie   ? {25'h0000000, int_en_r} :
    hit_ctrl ? {29'h00000000, ctrl_r} :
    hit_ci   ? ci_r :
    hit_tf   ? tf_word :
    hit_bc   ? acc.byte_count :
    hit_dw   ? {1'b0, limit_r} : 32'h00000000;

  assign acc.cmd_start   = cmd_start;
  assign acc.queued      = cmd_queued;
  assign acc.limit_words = limit_r;
  assign acc.fis_end     = fis_end;
  assign acc.fis_good    = fis_good;
  assign acc.fis_words   = fis_words;
  assign acc.prd_exhaust = prd_exhaust;
  assign acc.prd_ibit    = prd_ibit;
  assign acc.tx_dword    = tx_dword;
  assign acc.tx_odd_last = tx_odd_last;

  // In idle, a sync escape outranks all other errors since it must
  // stop transmission; only one error is taken per idle visit.
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SPA_IDLE, SPA_SW_IDLE:
        if (ev_sync_esc_reg && fbs_en)
          state_nxt = SPA_SYNC_FB;
        else if (ev_sync_esc_reg || ev_sync_esc_data)
          state_nxt = SPA_SYNC_ESC;
        else if (ev_fatal)
          state_nxt = SPA_FATAL;
        else if (ev_tf_err)
          state_nxt = SPA_FATAL_TF;
        else if (ev_bad_pm_port)
          state_nxt = SPA_BAD_PORT;
        else if (ev_nonfatal || acc.ncq_under)
          state_nxt = SPA_NONFATAL;
        else if (cmd_done)
          state_nxt = SPA_WRBACK;
      SPA_WRBACK:   if (bc_wb_ack) state_nxt = ret_idle;
      SPA_BAD_PORT: state_nxt = SPA_NONFATAL;
      SPA_SYNC_ESC: state_nxt = SPA_FATAL;
      SPA_SYNC_FB:  state_nxt = SPA_SDE;
      SPA_FATAL:    state_nxt = SPA_WAIT_CLR;
      SPA_FATAL_TF: state_nxt = fbs_en ? SPA_SDE : SPA_WAIT_CLR;
      SPA_WAIT_CLR: if (!run_en) state_nxt = SPA_IDLE;
      SPA_NONFATAL: state_nxt = ret_idle;
      SPA_SDE:      if (sde_done) state_nxt = SPA_SW_IDLE;
      default:      state_nxt = SPA_IDLE;
    endcase
  end

  always_comb
  begin
    flag_set = '0;
    flag_set[SPA_F_IPM]  = state_r == SPA_BAD_PORT;
    flag_set[SPA_F_IFS]  = state_r == SPA_FATAL;
    flag_set[SPA_F_INFS] = state_r == SPA_SYNC_FB ||
                           state_r == SPA_NONFATAL && acc.ncq_under;
    flag_set[SPA_F_PSS]  = state_r == SPA_FATAL && pio_ibit_r;
    flag_set[SPA_F_TFES] = state_r == SPA_FATAL_TF;
    flag_set[SPA_F_OFS]  = acc.ovf;
    flag_set[SPA_F_DPS]  = acc.dps;
  end
  // A set in the same cycle as a software clear wins.
  assign flags_nxt = (flags_r & ~w1c_clr) | flag_set;

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      state_r  <= SPA_IDLE;
      flags_r  <= SPA_FLAG_RST;
      int_en_r <= SPA_FLAG_RST;
      ctrl_r   <= SPA_CTRL_RST;
      ci_r     <= 32'h00000000;
      limit_r  <= SPA_WORDS_RST;
    end
    else
    begin
      state_r  <= state_nxt;
      flags_r  <= flags_nxt;
      // Hardware clears issue bits only after the write-back.
      ci_r     <= (ci_r & ~ci_hw_clr) | ci_sw_set;
      if (wr && hit_ie)
        int_en_r <= wdat[SPA_NFLAG-1:0];
      if (wr && hit_ctrl)
        ctrl_r <= wdat[2:0];
      if (wr && hit_dw)
        limit_r <= wdat[30:0];
    end

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      tf_busy_r  <= 1'b0;
      tf_drq_r   <= 1'b0;
      busy_sh_r  <= 1'b0;
      drq_sh_r   <= 1'b0;
      pio_ibit_r <= 1'b0;
      no_retry_r <= 1'b0;
    end
    else
    begin
      // Taskfile bits clear first, shadows in the same step.
      if (state_r == SPA_SYNC_ESC)
      begin
        tf_busy_r <= 1'b0;
        tf_drq_r  <= 1'b0;
        busy_sh_r <= 1'b0;
        drq_sh_r  <= 1'b0;
      end
      else if (dev_stat_valid)
      begin
        tf_busy_r <= dev_busy;
        tf_drq_r  <= dev_drq;
        busy_sh_r <= dev_busy;
        drq_sh_r  <= dev_drq;
      end
      // A sync escape outranks the fatal event, so the qualifier is
      // cleared then and never leaks into a later fatal entry.
      if (in_idle)
        pio_ibit_r <= state_nxt == SPA_FATAL && ev_fatal_pio_ibit;
      // The aborted frame stays blocked until software stops the port.
      if (state_r == SPA_SYNC_ESC || state_r == SPA_SYNC_FB)
        no_retry_r <= 1'b1;
      else if (!run_en)
        no_retry_r <= 1'b0;
    end

  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      slot_r  <= 5'h00;
      count_r <= 32'h00000000;
      ack_r   <= 1'b0;
      rdat_r  <= 32'h00000000;
    end
    else
    begin
      if (in_idle && state_nxt == SPA_WRBACK)
      begin
        slot_r  <= cmd_slot;
        count_r <= acc.byte_count;
      end
      ack_r  <= req;
      rdat_r <= req ? rd_mux : 32'h00000000;
    end

  assign wb_ack_o             = ack_r;
  assign wb_dat_o             = rdat_r;
  assign bc_wb_valid          = state_r == SPA_WRBACK;
  assign bc_wb_slot           = slot_r;
  assign bc_wb_count          = count_r;
  assign tx_dword_pad         = acc.tx_dword_pad;
  assign tx_no_retry          = no_retry_r;
  assign command_issue_bits   = ci_r;
  // Running drops at once on a fatal error and whenever stopped.
  assign command_list_running = run_en && !fatal_st;
  // Each flag reaches the line only through its enable.
  assign irq = gie && |(flags_r & int_en_r);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  ipm_path_a: assert property (state_r == SPA_BAD_PORT |=>
    flags_r[SPA_F_IPM] && state_r == SPA_NONFATAL)
    else $error("invalid port flag or path wrong");
  sync_clear_a: assert property (state_r == SPA_SYNC_ESC |=>
    !tf_busy_r && !tf_drq_r && !busy_sh_r && !drq_sh_r &&
    state_r == SPA_FATAL ##1 flags_r[SPA_F_IFS] &&
    state_r == SPA_WAIT_CLR)
    else $error("sync escape sequence wrong");
  no_retry_a: assert property (state_r == SPA_SYNC_ESC |=>
    tx_no_retry [*2])
    else $error("aborted frame not blocked");
  ci_hold_a: assert property (
    (!fatal_st && state_r != SPA_SYNC_FB) or
    ci_sw_set != 32'h00000000 or state_r == SPA_WRBACK or
    ##1 ci_r == $past(ci_r))
    else $error("issue bits changed in error handling");
  fb_sync_a: assert property (state_r == SPA_SYNC_FB |=>
    flags_r[SPA_F_INFS] && state_r == SPA_SDE)
    else $error("switched sync escape path wrong");
  wait_hold_a: assert property (state_r == SPA_WAIT_CLR && run_en |=>
    state_r == SPA_WAIT_CLR)
    else $error("left wait state while still running");
  pss_set_a: assert property (state_r == SPA_FATAL && pio_ibit_r |=>
    flags_r[SPA_F_PSS])
    else $error("pio setup flag not set on fatal");
  tf_route_a: assert property (state_r == SPA_FATAL_TF |=>
    flags_r[SPA_F_TFES] &&
    state_r == ($past(fbs_en) ? SPA_SDE : SPA_WAIT_CLR))
    else $error("taskfile error route wrong");
  cr_drop_a: assert property (!run_en |-> !command_list_running)
    else $error("running shown while stopped");
  nf_ret_a: assert property (state_r == SPA_NONFATAL |=>
    state_r == ($past(fbs_en) ? SPA_SW_IDLE : SPA_IDLE))
    else $error("non-fatal return state wrong");
  wb_order_a: assert property (bc_wb_valid && !bc_wb_ack |=>
    ci_r[slot_r] || $past(ci_sw_set) == 32'h00000000 && !$past(ci_r[slot_r]))
    else $error("issue bit cleared before count write-back");
  sticky_a: assert property (##1 (($past(flags_r) & ~$past(w1c_clr)
    & ~flags_r) == '0))
    else $error("error flag lost without software clear");
  dps_irq_a: assert property (flags_r[SPA_F_DPS] &&
    int_en_r[SPA_F_DPS] && gie |-> irq)
    else $error("descriptor done interrupt missing");
  fatal_c: cover property (state_r == SPA_SYNC_ESC ##1 state_r == SPA_FATAL
    ##[1:20] state_r == SPA_IDLE);
  nonfatal_c: cover property (state_r == SPA_BAD_PORT ##2 in_idle);
  wrback_c: cover property (bc_wb_valid ##[0:10] bc_wb_ack);
  dps_c: cover property (flag_set[SPA_F_DPS] ##1 irq);
endmodule // spa_port_err
`default_nettype wire

// ---- verif/spa_dev_model.sv ----
`default_nettype none
module spa_dev_model
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Bench control
  input  wire logic       stat_go,
  input  wire logic [3:0] ack_lat,
  // Port side
  input  wire logic       bc_wb_valid,
  output logic            dev_stat_valid,
  output logic            dev_busy,
  output logic            dev_drq,
  output logic            bc_wb_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // Busy and data-request follow the report strobe, so they carry no
  // stale level outside a report.
  // The write-back is answered after a chosen delay, so a slow memory
  // path is exercised and not only a prompt one.
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dev_stat_valid <= 1'b0;
      dev_busy       <= 1'b0;
      dev_drq        <= 1'b0;
      bc_wb_ack      <= 1'b0;
      wait_r         <= 4'h0;
    end
    else
    begin
      dev_stat_valid <= stat_go;
      dev_busy       <= stat_go;
      dev_drq        <= stat_go;
      bc_wb_ack      <= 1'b0;
      if (bc_wb_valid && !bc_wb_ack)
      begin
        wait_r <= (wait_r == ack_lat) ? 4'h0 : wait_r + 4'h1;
        bc_wb_ack <= (wait_r == ack_lat);
      end
    end
  end
endmodule  // spa_dev_model
`default_nettype wire

// ---- verif/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spa_pkg::*;
  typedef struct packed {
    logic [2:0] ev;
    logic       fbs;
    logic       pio;
    logic [6:0] fl;
    spa_state_t st;
  } spa_row_t;
  localparam spa_row_t ROWS [11] = '{
    '{3'h0, 1'b0, 1'b0, 7'h01, SPA_IDLE},
    '{3'h0, 1'b1, 1'b0, 7'h01, SPA_SW_IDLE},
    '{3'h4, 1'b0, 1'b0, 7'h10, SPA_WAIT_CLR},
    '{3'h4, 1'b1, 1'b0, 7'h10, SPA_SDE},
    '{3'h1, 1'b1, 1'b0, 7'h04, SPA_SDE},
    '{3'h2, 1'b0, 1'b0, 7'h02, SPA_WAIT_CLR},
    '{3'h1, 1'b0, 1'b0, 7'h02, SPA_WAIT_CLR},
    '{3'h3, 1'b0, 1'b1, 7'h0A, SPA_WAIT_CLR},
    '{3'h3, 1'b0, 1'b0, 7'h02, SPA_WAIT_CLR},
    '{3'h5, 1'b1, 1'b0, 7'h00, SPA_SW_IDLE},
    '{3'h5, 1'b0, 1'b0, 7'h00, SPA_IDLE}};
  logic        mclk, sys_rst, cyc, stb, we, ack, pio, sde_done, dvv;
  logic        dbs, ddr, cmd_done, bcv, bca, cst, cq, fe, fg, pe, pi;
  logic        txo, nr, clr, irq, stat_go;
  logic [3:0]  sel;
  logic [4:0]  slot, bcs;
  logic [5:0]  ev;
  logic [7:0]  adr;
  logic [12:0] fw;
  logic [31:0] dat_i, dat_o, bcc, txd, txp, ci, q;
  int          miscompares, comparisons;

  spa_port_err i_dut (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .ev_bad_pm_port(ev[0]), .ev_sync_esc_reg(ev[1]),
    .ev_sync_esc_data(ev[2]), .ev_fatal(ev[3]), .ev_fatal_pio_ibit(pio),
    .ev_tf_err(ev[4]), .ev_nonfatal(ev[5]), .sde_done(sde_done),
    .dev_stat_valid(dvv), .dev_busy(dbs), .dev_drq(ddr),
    .cmd_done(cmd_done), .cmd_slot(slot), .bc_wb_valid(bcv),
    .bc_wb_slot(bcs), .bc_wb_count(bcc), .bc_wb_ack(bca),
    .cmd_start(cst), .cmd_queued(cq), .fis_end(fe), .fis_good(fg),
    .fis_words(fw), .prd_exhaust(pe), .prd_ibit(pi), .tx_dword(txd),
    .tx_odd_last(txo), .tx_dword_pad(txp), .tx_no_retry(nr),
    .command_list_running(clr), .command_issue_bits(ci), .irq(irq));
  spa_dev_model i_dev (.mclk(mclk), .sys_rst(sys_rst), .stat_go(stat_go),
    .ack_lat(4'h3), .bc_wb_valid(bcv), .dev_stat_valid(dvv),
    .dev_busy(dbs), .dev_drq(ddr), .bc_wb_ack(bca));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d, errors %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= d;
    @(posedge mclk);
    while (ack !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge mclk);
    end
    if (ack !== 1'b1)
      miscompares++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic fis(input logic g, input logic [12:0] w);
    @(posedge mclk);
    fe <= 1'b1;
    fg <= g;
    fw <= w;
    @(posedge mclk);
    fe <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  initial
  begin
    #100000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    spa_row_t r;
    int n;
    {cyc, stb, we, pio, sde_done, cmd_done, cst, cq, fe, fg} = '0;
    {pe, pi, txo, stat_go, ev, adr, fw, dat_i, txd, slot} = '0;
    sel = 4'hF;
    miscompares = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    wb(1'b0, SPA_OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, SPA_OFS_CMD_ISS, 32'h5);
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      wb(1'b1, SPA_OFS_CONTROL, {30'h0, r.fbs, 1'b1});
      @(posedge mclk);
      stat_go <= 1'b1;
      @(posedge mclk);
      stat_go <= 1'b0;
      repeat (2) @(posedge mclk);
      ev <= 6'h01 << r.ev;
      pio <= r.pio;
      @(posedge mclk);
      ev <= 6'h00;
      pio <= 1'b0;
      repeat (4) @(posedge mclk);
      wb(1'b0, SPA_OFS_STATUS, 32'h0);
      chk(q, {25'h0, r.fl});
      wb(1'b0, SPA_OFS_TFSTAT, 32'h0);
      chk(q[11:8], r.st);
      chk(ci, 32'h5);
      if (r.st == SPA_WAIT_CLR && r.ev inside {3'h1, 3'h2})
      begin
        chk({q[7], q[3], nr}, 3'b001);
      end
      if (r.st == SPA_WAIT_CLR)
      begin
        wb(1'b1, SPA_OFS_CONTROL, {30'h0, r.fbs, 1'b0});
        chk(clr, 1'b0);
      end
      if (r.st == SPA_SDE)
      begin
        sde_done <= 1'b1;
        @(posedge mclk);
        sde_done <= 1'b0;
      end
      wb(1'b1, SPA_OFS_STATUS, 32'h7F);
      wb(1'b0, SPA_OFS_STATUS, 32'h0);
      chk(q, 32'h0);
    end
    wb(1'b1, SPA_OFS_CONTROL, 32'h1);
    wb(1'b1, SPA_OFS_CMD_ISS, 32'h8);
    wb(1'b1, SPA_OFS_DESCWRD, 32'h100);
    cst <= 1'b1;
    @(posedge mclk);
    cst <= 1'b0;
    fis(1'b1, 13'd5);
    fis(1'b0, 13'd7);
    fis(1'b1, 13'd5);
    wb(1'b0, SPA_OFS_BYTECNT, 32'h0);
    chk(q, 32'd20);
    cmd_done <= 1'b1;
    slot <= 5'd3;
    @(posedge mclk);
    cmd_done <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({bcv, bcs, bcc}, {1'b1, 5'd3, 32'd20});
    chk(ci, 32'hD);
    n = 0;
    while (bca !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk);
    end
    if (bca !== 1'b1)
      miscompares++;
    repeat (2) @(posedge mclk);
    chk({bcv, ci}, {1'b0, 32'h5});
    wb(1'b1, SPA_OFS_DESCWRD, 32'h9);
    cst <= 1'b1;
    @(posedge mclk);
    cst <= 1'b0;
    fis(1'b1, 13'd10);
    wb(1'b0, SPA_OFS_BYTECNT, 32'h0);
    chk(q, 32'd18);
    wb(1'b0, SPA_OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    fis(1'b1, 13'd3);
    wb(1'b0, SPA_OFS_STATUS, 32'h0);
    chk(q, 32'h20);
    wb(1'b1, SPA_OFS_STATUS, 32'h20);
    cq <= 1'b1;
    cst <= 1'b1;
    @(posedge mclk);
    cst <= 1'b0;
    fis(1'b1, 13'd4);
    wb(1'b0, SPA_OFS_BYTECNT, 32'h0);
    chk(q, 32'h0);
    cq <= 1'b0;
    @(posedge mclk);
    txd <= 32'hABCD1234;
    txo <= 1'b1;
    @(posedge mclk);
    txo <= 1'b0;
    @(posedge mclk);
    chk(txp, 32'h00001234);
    @(posedge mclk);
    chk(txp, 32'hABCD1234);
    wb(1'b1, SPA_OFS_INT_EN, 32'h40);
    wb(1'b1, SPA_OFS_CONTROL, 32'h5);
    for (int k = 0; k < 2; k++)
    begin
      pe <= 1'b1;
      pi <= 1'b1;
      @(posedge mclk);
      pe <= 1'b0;
      repeat (3) @(posedge mclk);
      chk(irq, 1'b0);
      fis(k == 0, 13'd4);
      chk(irq, k == 0);
      wb(1'b0, SPA_OFS_STATUS, 32'h0);
      chk(q, (k == 0) ? 32'h40 : 32'h0);
      wb(1'b1, SPA_OFS_STATUS, 32'h40);
      chk(irq, 1'b0);
    end
    // A reset in mid-run must clear ack, irq, running, write-back valid, no-retry, issue bits, control and taskfile status.
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk({ack, irq, clr, bcv, nr}, 5'h00);
    chk(ci, 32'h0);
    sys_rst <= 1'b0;
    wb(1'b0, SPA_OFS_CONTROL, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, SPA_OFS_TFSTAT, 32'h0);
    chk(q, 32'h0);
    give_verdict();
  end
endmodule  // tb
`default_nettype wire
